// ==== src/otpcfg_regs.svh ====
`ifndef OTPCFG_REGS_SVH
`define OTPCFG_REGS_SVH

// ============================================================
// Register offsets.
`define OTPCFG_OFS_OVERRIDES   9'h007
`define OTPCFG_OFS_TOGGLE_FN   9'h00A
`define OTPCFG_OFS_DIR_LO      9'h00B
`define OTPCFG_OFS_DIR_HI      9'h00C
`define OTPCFG_OFS_MASK_LO     9'h00D
`define OTPCFG_OFS_MASK_HI     9'h00E
`define OTPCFG_OFS_RATE_B0     9'h00F
`define OTPCFG_OFS_RATE_B1     9'h010
`define OTPCFG_OFS_RATE_B2     9'h011
`define OTPCFG_OFS_MAKER_LO    9'h012
`define OTPCFG_OFS_MAKER_HI    9'h013
`define OTPCFG_OFS_PART_LO     9'h014
`define OTPCFG_OFS_PART_HI     9'h015
`define OTPCFG_OFS_POWER       9'h016
`define OTPCFG_OFS_ATTRIB      9'h017
`define OTPCFG_OFS_PROG1       9'h01E

// ============================================================
// Writable bit masks; reserved positions are zero.
`define OTPCFG_WMASK_FULL      8'hFF
`define OTPCFG_WMASK_TWO       8'h03
`define OTPCFG_WMASK_ATTRIB    8'h0F
`define OTPCFG_WMASK_OVR       8'h1F

// ============================================================
// Field positions.
`define OTPCFG_BIT_TX_TOGGLE   0
`define OTPCFG_BIT_RX_TOGGLE   1
`define OTPCFG_BIT_WAKE_VALID  2
`define OTPCFG_BIT_WAKE_EN     3
`define OTPCFG_BIT_OVR_DIR     2
`define OTPCFG_BIT_OVR_MASK    3
`define OTPCFG_BIT_OVR_RATE    4
`define OTPCFG_BIT_PROG_VID    0
`define OTPCFG_BIT_PROG_PID    1
`define OTPCFG_BIT_PROG_POWER  2
`define OTPCFG_BIT_PROG_ATTR   3
`define OTPCFG_DESC_D5         5
`define OTPCFG_DESC_D6         6
`define OTPCFG_DESC_D7         7

// ============================================================
// Reset values and limits.
`define OTPCFG_RST_BYTE        8'h00
`define OTPCFG_POWER_MIN       8'h01
`define OTPCFG_POWER_MAX       8'hFA
`define OTPCFG_DESC_BASE       8'h80

`endif

// ==== src/otpcfg_pkg.sv ====
package otpcfg_pkg;

  // ============================================================
  // Power mode decode.
  typedef enum logic [1:0] {
    OTPCFG_PWR_BUS,
    OTPCFG_PWR_SELF,
    OTPCFG_PWR_INVALID
  } otpcfg_pwr_t;

  // Register access request from the host side.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } otpcfg_req_t;

  // Effective configuration presented to the channel.
  typedef struct packed {
    logic [9:0]  pin_dir;
    logic [9:0]  pin_mask;
    logic [23:0] rate_limit;
    logic        tx_toggle_pin;
    logic        rx_toggle_pin;
  } otpcfg_chan_t;

  // Descriptor values presented to the USB engine.
  typedef struct packed {
    logic [15:0] maker_id;
    logic [15:0] part_id;
    logic [7:0]  max_power;
    logic        power_valid;
    logic [7:0]  attributes;
    otpcfg_pwr_t power_mode;
  } otpcfg_desc_t;

endpackage

// ==== src/otpcfg_mem.sv ====
`include "otpcfg_regs.svh"

// Byte store for the configuration bank; read data is registered.
module otpcfg_mem (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Access
  input  wire logic       i_we,
  input  wire logic [4:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [4:0] i_raddr,
  output logic      [7:0] o_rdata
);

  logic [7:0] mem [0:31];
  logic [7:0] rdata;

  // ============================================================
  // Store writes and register the read word, cleared on reset.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 32; i++) begin
        mem[i] <= `OTPCFG_RST_BYTE;
      end
      rdata <= `OTPCFG_RST_BYTE;
    end else begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      rdata <= mem[i_raddr];
    end
  end

  assign o_rdata = rdata;

endmodule

// ==== src/otpcfg_bank.sv ====
`include "otpcfg_regs.svh"

module otpcfg_bank (
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  // Register access from the USB side
  input  otpcfg_pkg::otpcfg_req_t     i_req,
  output logic [7:0]                  o_rdata,
  output logic                        o_rvalid,
  // Built-in class defaults
  input  wire logic [9:0]             i_dflt_dir,
  input  wire logic [9:0]             i_dflt_mask,
  input  wire logic [23:0]            i_dflt_rate,
  input  wire logic [15:0]            i_dflt_maker,
  input  wire logic [15:0]            i_dflt_part,
  input  wire logic [7:0]             i_dflt_power,
  input  wire logic [7:0]             i_dflt_attr,
  // Pin change events from the pin sampler
  input  wire logic [9:0]             i_pin_change,
  // Effective configuration and events
  output otpcfg_pkg::otpcfg_chan_t    o_chan,
  output otpcfg_pkg::otpcfg_desc_t    o_desc,
  output logic [9:0]                  o_change_pkt
);

  // All module state in one packed struct.
  typedef struct packed {
    logic [7:0]               ovr;
    logic [7:0]               toggle_fn;
    logic [7:0]               dir_lo;
    logic [7:0]               dir_hi;
    logic [7:0]               mask_lo;
    logic [7:0]               mask_hi;
    logic [7:0]               rate_b0;
    logic [7:0]               rate_b1;
    logic [7:0]               rate_b2;
    logic [7:0]               maker_lo;
    logic [7:0]               maker_hi;
    logic [7:0]               part_lo;
    logic [7:0]               part_hi;
    logic [7:0]               power;
    logic [7:0]               attrib;
    logic [7:0]               prog1;
    logic                     rvalid;
    otpcfg_pkg::otpcfg_chan_t chan;
    otpcfg_pkg::otpcfg_desc_t desc;
    logic [9:0]               change_pkt;
  } otpcfg_state_t;

  otpcfg_state_t st;
  otpcfg_state_t next_st;
  logic [7:0]    mem_rdata;

  // ============================================================
  // Write mask for each offset; zero marks an unmapped offset.
  function automatic logic [7:0] wmask(input logic [8:0] a);
    case (a)
      `OTPCFG_OFS_OVERRIDES: wmask = `OTPCFG_WMASK_OVR;
      `OTPCFG_OFS_TOGGLE_FN,
      `OTPCFG_OFS_DIR_HI,
      `OTPCFG_OFS_MASK_HI:   wmask = `OTPCFG_WMASK_TWO;
      `OTPCFG_OFS_ATTRIB:    wmask = `OTPCFG_WMASK_ATTRIB;
      `OTPCFG_OFS_DIR_LO,
      `OTPCFG_OFS_MASK_LO,
      `OTPCFG_OFS_RATE_B0,
      `OTPCFG_OFS_RATE_B1,
      `OTPCFG_OFS_RATE_B2,
      `OTPCFG_OFS_MAKER_LO,
      `OTPCFG_OFS_MAKER_HI,
      `OTPCFG_OFS_PART_LO,
      `OTPCFG_OFS_PART_HI,
      `OTPCFG_OFS_POWER,
      `OTPCFG_OFS_PROG1:     wmask = `OTPCFG_WMASK_FULL;
      default:               wmask = 8'h00;
    endcase
  endfunction

  // Power mode decode, used twice by the descriptor logic.
  function automatic otpcfg_pkg::otpcfg_pwr_t pwr_decode(input logic [1:0] f);
    case (f)
      2'h0:    pwr_decode = otpcfg_pkg::OTPCFG_PWR_BUS;
      2'h1,
      2'h2:    pwr_decode = otpcfg_pkg::OTPCFG_PWR_SELF;
      default: pwr_decode = otpcfg_pkg::OTPCFG_PWR_INVALID;
    endcase
  endfunction

  logic       wr_hit;
  logic [7:0] wr_val;
  logic [7:0] wr_byte;
  logic [4:0] rd_addr;
  assign wr_hit = i_req.wr && (wmask(i_req.addr) != 8'h00);
  assign wr_val = i_req.wdata & wmask(i_req.addr);

  // The flag byte only ever gains bits, so its shadow copy merges the old
  // flags in too; otherwise a read would hide flags that the logic still holds.
  assign wr_byte = (i_req.addr == `OTPCFG_OFS_PROG1) ? (st.prog1 | wr_val) : wr_val;

  // Unmapped offsets are steered to slot zero, which is never written, so the
  // read byte leaves the store register directly with no mux behind it.
  assign rd_addr = (wmask(i_req.addr) != 8'h00) ? i_req.addr[4:0] : 5'h00;

  // ============================================================
  // Shadow store: keeps a readable copy of every mapped byte so reads
  // come from one registered port rather than a wide mux.
  otpcfg_mem u_mem (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_we      (wr_hit),
    .i_waddr   (i_req.addr[4:0]),
    .i_wdata   (wr_byte),
    .i_raddr   (rd_addr),
    .o_rdata   (mem_rdata)
  );

  // ============================================================
  // Next-state logic: byte writes, then effective values.
  always_comb begin
    next_st = st;
    next_st.rvalid  = i_req.rd;
    if (wr_hit) begin
      case (i_req.addr)
        `OTPCFG_OFS_OVERRIDES: next_st.ovr       = wr_val;
        `OTPCFG_OFS_TOGGLE_FN: next_st.toggle_fn = wr_val;
        `OTPCFG_OFS_DIR_LO:    next_st.dir_lo    = wr_val;
        `OTPCFG_OFS_DIR_HI:    next_st.dir_hi    = wr_val;
        `OTPCFG_OFS_MASK_LO:   next_st.mask_lo   = wr_val;
        `OTPCFG_OFS_MASK_HI:   next_st.mask_hi   = wr_val;
        `OTPCFG_OFS_RATE_B0:   next_st.rate_b0   = wr_val;
        `OTPCFG_OFS_RATE_B1:   next_st.rate_b1   = wr_val;
        `OTPCFG_OFS_RATE_B2:   next_st.rate_b2   = wr_val;
        `OTPCFG_OFS_MAKER_LO:  next_st.maker_lo  = wr_val;
        `OTPCFG_OFS_MAKER_HI:  next_st.maker_hi  = wr_val;
        `OTPCFG_OFS_PART_LO:   next_st.part_lo   = wr_val;
        `OTPCFG_OFS_PART_HI:   next_st.part_hi   = wr_val;
        `OTPCFG_OFS_POWER:     next_st.power     = wr_val;
        `OTPCFG_OFS_ATTRIB:    next_st.attrib    = wr_val;
        `OTPCFG_OFS_PROG1:     next_st.prog1     = st.prog1 | wr_val; // Flags only set.
        default:               next_st.ovr       = st.ovr;
      endcase
    end

    // Channel values track the stored bytes one cycle later.
    next_st.chan.tx_toggle_pin = st.toggle_fn[`OTPCFG_BIT_TX_TOGGLE];
    next_st.chan.rx_toggle_pin = st.toggle_fn[`OTPCFG_BIT_RX_TOGGLE];
    next_st.chan.pin_dir  = st.ovr[`OTPCFG_BIT_OVR_DIR] ?
                            {st.dir_hi[1:0], st.dir_lo} : i_dflt_dir;
    next_st.chan.pin_mask = st.ovr[`OTPCFG_BIT_OVR_MASK] ?
                            {st.mask_hi[1:0], st.mask_lo} : i_dflt_mask;
    next_st.chan.rate_limit = st.ovr[`OTPCFG_BIT_OVR_RATE] ?
                              {st.rate_b2, st.rate_b1, st.rate_b0} : i_dflt_rate;

    // Descriptor fields fall back to defaults until flagged programmed.
    next_st.desc.maker_id = st.prog1[`OTPCFG_BIT_PROG_VID] ?
                            {st.maker_hi, st.maker_lo} : i_dflt_maker;
    next_st.desc.part_id  = st.prog1[`OTPCFG_BIT_PROG_PID] ?
                            {st.part_hi, st.part_lo} : i_dflt_part;
    next_st.desc.max_power = st.prog1[`OTPCFG_BIT_PROG_POWER] ?
                             st.power : i_dflt_power;
    next_st.desc.power_valid = (next_st.desc.max_power >= `OTPCFG_POWER_MIN) &&
                               (next_st.desc.max_power <= `OTPCFG_POWER_MAX);
    begin
      logic [7:0] a;
      a = st.prog1[`OTPCFG_BIT_PROG_ATTR] ? st.attrib : i_dflt_attr;
      next_st.desc.power_mode = pwr_decode(a[1:0]);
      next_st.desc.attributes = `OTPCFG_DESC_BASE;
      next_st.desc.attributes[`OTPCFG_DESC_D6] = (pwr_decode(a[1:0]) ==
                                                 otpcfg_pkg::OTPCFG_PWR_SELF);
      next_st.desc.attributes[`OTPCFG_DESC_D5] =
        a[`OTPCFG_BIT_WAKE_VALID] & a[`OTPCFG_BIT_WAKE_EN];
    end

    // A pin change becomes a packet request unless masked.
    next_st.change_pkt = i_pin_change & ~st.chan.pin_mask;
  end

  // ============================================================
  // State register; synchronous reset clears every byte to zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Read byte comes straight from the store's output register.
  assign o_rdata      = mem_rdata;
  assign o_rvalid     = st.rvalid;
  assign o_chan       = st.chan;
  assign o_desc       = st.desc;
  assign o_change_pkt = st.change_pkt;

  // ============================================================
  // Assertions.
  // Checks that look back one edge, except a_mask_gate and a_wake_gate, skip the first edge after reset, because
  // the history sampled there still holds the state from before the reset.
  a_tx_toggle_map: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      o_chan.tx_toggle_pin == $past(st.toggle_fn[`OTPCFG_BIT_TX_TOGGLE]))
    else $error("tx toggle pin does not follow function bit");
  a_rx_toggle_map: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_sys_rst) |->
      o_chan.rx_toggle_pin == $past(st.toggle_fn[`OTPCFG_BIT_RX_TOGGLE]))
    else $error("rx toggle pin does not follow function bit");
  a_dir_override: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.ovr[`OTPCFG_BIT_OVR_DIR])) |->
      o_chan.pin_dir == $past({st.dir_hi[1:0], st.dir_lo}))
    else $error("pin direction ignores override bytes");
  a_dir_default: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(st.ovr[`OTPCFG_BIT_OVR_DIR])) |->
      o_chan.pin_dir == $past(i_dflt_dir))
    else $error("pin direction not default without override");
  a_mask_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (o_change_pkt & $past(o_chan.pin_mask)) == 10'h000)
    else $error("masked pin produced a packet");
  a_mask_pass: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_pin_change[9] && !o_chan.pin_mask[9]) |=> o_change_pkt[9])
    else $error("unmasked pin nine change lost");
  a_rate_order: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.ovr[`OTPCFG_BIT_OVR_RATE])) |->
      o_chan.rate_limit[23:16] == $past(st.rate_b2))
    else $error("rate limit top byte misplaced");
  a_maker_ident: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.prog1[`OTPCFG_BIT_PROG_VID])) |->
      o_desc.maker_id == $past({st.maker_hi, st.maker_lo}))
    else $error("maker identifier mis-assembled");
  a_part_ident: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.prog1[`OTPCFG_BIT_PROG_PID])) |->
      o_desc.part_id == $past({st.part_hi, st.part_lo}))
    else $error("part identifier mis-assembled");
  a_unprog_ident: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(st.prog1[`OTPCFG_BIT_PROG_VID])) |->
      o_desc.maker_id == $past(i_dflt_maker))
    else $error("unflagged maker identifier used");
  a_power_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_desc.power_valid == (o_desc.max_power != 8'h00 && o_desc.max_power <= 8'hFA))
    else $error("power validity wrong");
  a_wake_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_desc.attributes[`OTPCFG_DESC_D5] |-> $past(st.attrib[`OTPCFG_BIT_WAKE_VALID]) ||
      !$past(st.prog1[`OTPCFG_BIT_PROG_ATTR]))
    else $error("wake advertised without gate");
  a_wake_adv: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.prog1[`OTPCFG_BIT_PROG_ATTR]) &&
     $past(st.attrib[3:2]) == 2'h3) |->
      o_desc.attributes[`OTPCFG_DESC_D5])
    else $error("wake enable not advertised");
  a_power_mode: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.prog1[`OTPCFG_BIT_PROG_ATTR]) &&
     $past(st.attrib[1:0]) == 2'h3) |->
      o_desc.power_mode == otpcfg_pkg::OTPCFG_PWR_INVALID)
    else $error("power mode 11 not invalid");
  a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_req.wr && i_req.addr == `OTPCFG_OFS_TOGGLE_FN) |=> st.toggle_fn[7:2] == 6'h00)
    else $error("reserved bits stored");
  a_read_latency: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    i_req.rd |=> o_rvalid)
    else $error("read not answered next cycle");
  a_rate_bytes: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.ovr[`OTPCFG_BIT_OVR_RATE])) |->
      o_chan.rate_limit == $past({st.rate_b2, st.rate_b1, st.rate_b0}))
    else $error("rate limit bytes out of order");
  a_rate_default: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(st.ovr[`OTPCFG_BIT_OVR_RATE])) |->
      o_chan.rate_limit == $past(i_dflt_rate))
    else $error("rate limit not default without override");
  a_mask_default: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(st.ovr[`OTPCFG_BIT_OVR_MASK])) |->
      o_chan.pin_mask == $past(i_dflt_mask))
    else $error("pin mask not default without override");
  a_mask_override: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.ovr[`OTPCFG_BIT_OVR_MASK])) |->
      o_chan.pin_mask == $past({st.mask_hi[1:0], st.mask_lo}))
    else $error("pin mask ignores override bytes");
  a_power_take: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && $past(st.prog1[`OTPCFG_BIT_PROG_POWER])) |->
      o_desc.max_power == $past(st.power))
    else $error("programmed power byte not reported");
  a_unprog_part: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (!$past(i_sys_rst) && !$past(st.prog1[`OTPCFG_BIT_PROG_PID])) |->
      o_desc.part_id == $past(i_dflt_part))
    else $error("unflagged part identifier used");
  // Programmed flags are one-way: once set, only a reset may clear them.
  a_flags_sticky: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    !$past(i_sys_rst) |-> (st.prog1 & $past(st.prog1)) == $past(st.prog1))
    else $error("programmed flag cleared");
  a_unmapped_read: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (i_req.rd && wmask(i_req.addr) == 8'h00) |=> o_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  c_dir_override: cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st.ovr[`OTPCFG_BIT_OVR_DIR] && o_chan.pin_dir != 10'h000);
  c_wake_adv:     cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_desc.attributes[`OTPCFG_DESC_D5]);
  c_change_pkt:   cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_change_pkt != 10'h000);
  c_maker_prog:   cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    st.prog1[`OTPCFG_BIT_PROG_VID]);
  c_read_data:    cover property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    o_rvalid && o_rdata != 8'h00);

endmodule

// ==== verification/otpcfg_host_model.sv ====
`include "otpcfg_regs.svh"

// ============================================================
// Host side model: issues single-cycle byte accesses to the bank.
module otpcfg_host_model (
  // Clock
  input  wire logic               i_clk_sys,
  // Access towards the bank
  output otpcfg_pkg::otpcfg_req_t o_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle address and data start at a pattern no register decodes.
  initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 9'h1FF, wdata: 8'hFF};

  // A careful host clears every reserved bit before it writes.
  function automatic logic [7:0] legal(input logic [8:0] a, input logic [7:0] d);
    case (a)
      `OTPCFG_OFS_TOGGLE_FN, `OTPCFG_OFS_DIR_HI, `OTPCFG_OFS_MASK_HI: return d & `OTPCFG_WMASK_TWO;
      `OTPCFG_OFS_ATTRIB:    return d & `OTPCFG_WMASK_ATTRIB;
      `OTPCFG_OFS_OVERRIDES: return d & `OTPCFG_WMASK_OVR;
      default:               return d;
    endcase
  endfunction

  // One access: launched at a falling edge, taken at the next rising edge.
  // Afterwards address and data show the inverse, so no stale value lingers.
  task automatic access(input logic wr, input logic [8:0] a, input logic [7:0] d,
                        input logic keep);
    @(negedge i_clk_sys);
    o_req <= '{wr: wr, rd: ~wr, addr: a, wdata: keep ? legal(a, d) : d};
    @(negedge i_clk_sys);
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

// ==== verification/tb_top.sv ====
`include "otpcfg_regs.svh"

// ============================================================
// Self-checking bench for the configuration bank.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     i_clk_sys;
  logic                     i_sys_rst;
  otpcfg_pkg::otpcfg_req_t  req;
  logic [7:0]               o_rdata;
  logic                     o_rvalid;
  logic [9:0]               dflt_dir;
  logic [9:0]               dflt_mask;
  logic [23:0]              dflt_rate;
  logic [15:0]              dflt_maker;
  logic [15:0]              dflt_part;
  logic [7:0]               dflt_power;
  logic [7:0]               dflt_attr;
  logic [9:0]               pin_change;
  otpcfg_pkg::otpcfg_chan_t o_chan;
  otpcfg_pkg::otpcfg_desc_t o_desc;
  logic [9:0]               o_change_pkt;
  logic [7:0]               v[14];
  logic [7:0]               exp_q[$];
  logic [7:0]               pw[5];
  logic [9:0]               mask;
  integer                   seed;
  int                       n_errors;
  int                       tests_run;

  otpcfg_host_model i_host (.i_clk_sys(i_clk_sys), .o_req(req));

  otpcfg_bank i_dut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_req(req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_dflt_dir(dflt_dir), .i_dflt_mask(dflt_mask),
    .i_dflt_rate(dflt_rate), .i_dflt_maker(dflt_maker), .i_dflt_part(dflt_part),
    .i_dflt_power(dflt_power), .i_dflt_attr(dflt_attr), .i_pin_change(pin_change),
    .o_chan(o_chan), .o_desc(o_desc), .o_change_pkt(o_change_pkt)
  );

  // ============================================================
  // Clock, checks and closing.
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Read results are matched against the oldest note; a stray pulse also counts.
  initial forever begin
    @(negedge i_clk_sys);
    if (o_rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("spurious rvalid", 24'h0, 24'h1);
      else
        chk("rdata", exp_q.pop_front(), o_rdata);
    end
  end

  // A hang is cut short well after the sequence should have ended.
  initial begin
    #500000;
    n_errors++;
    give_verdict();
  end

  // ============================================================
  // Access helpers; effects on the outputs are looked at once they settle.
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic keep = 1'b1);
    i_host.access(1'b1, a, d, keep);
    repeat (3) @(negedge i_clk_sys);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, a, 8'h00, 1'b1);
  endtask

  function automatic logic [7:0] wmask(input int i);
    return (i == 0 || i == 2 || i == 4) ? 8'h03 : (i == 13) ? 8'h0F : 8'hFF;
  endfunction

  // ============================================================
  // Main sequence.
  initial begin
    seed = 32'hF049;
    n_errors = 0;
    tests_run = 0;
    pin_change = 10'h000;
    {dflt_dir, dflt_mask, dflt_rate} = 44'({$random(seed), $random(seed)});
    {dflt_maker, dflt_part, dflt_power, dflt_attr} = 48'({$random(seed), $random(seed)});
    pw = '{8'h00, 8'h01, 8'hFA, 8'hFB, 8'h00};
    for (int i = 0; i < 14; i++) v[i] = 8'($random(seed));
    pw[4] = v[12];
    i_sys_rst = 1'b1;
    repeat (6) @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    for (int i = 0; i < 14; i++) rd(9'h00A + 9'(i), 8'h00);
    chk("pin_dir", 24'(dflt_dir), 24'(o_chan.pin_dir));
    chk("maker_id", 24'(dflt_maker), 24'(o_desc.maker_id));
    for (int t = 0; t < 4; t++) begin
      wr(`OTPCFG_OFS_TOGGLE_FN, 8'(t));
      chk("tx_toggle", 24'(t % 2), 24'(o_chan.tx_toggle_pin));
      chk("rx_toggle", 24'(t / 2), 24'(o_chan.rx_toggle_pin));
    end
    // Stored bytes must not reach the outputs before their gates open.
    for (int i = 0; i < 14; i++) wr(9'h00A + 9'(i), v[i]);
    chk("pin_mask", 24'(dflt_mask), 24'(o_chan.pin_mask));
    chk("rate", dflt_rate, o_chan.rate_limit);
    chk("part_id", 24'(dflt_part), 24'(o_desc.part_id));
    for (int i = 0; i < 14; i++) rd(9'h00A + 9'(i), v[i] & wmask(i));
    wr(`OTPCFG_OFS_OVERRIDES, 8'h1C);
    mask = {v[4][1:0], v[3]};
    chk("pin_dir", 24'({v[2][1:0], v[1]}), 24'(o_chan.pin_dir));
    chk("pin_mask", 24'(mask), 24'(o_chan.pin_mask));
    chk("rate", {v[7], v[6], v[5]}, o_chan.rate_limit);
    for (int k = 0; k < 8; k++) begin
      pin_change = (k == 0) ? 10'h3FF : 10'($random(seed));
      @(negedge i_clk_sys);
      chk("change_pkt", 24'(pin_change & ~mask), 24'(o_change_pkt));
    end
    pin_change = 10'h000;
    wr(`OTPCFG_OFS_PROG1, 8'h0F);
    chk("maker_id", 24'({v[9], v[8]}), 24'(o_desc.maker_id));
    chk("part_id", 24'({v[11], v[10]}), 24'(o_desc.part_id));
    foreach (pw[i]) begin
      wr(`OTPCFG_OFS_POWER, pw[i]);
      chk("max_power", 24'(pw[i]), 24'(o_desc.max_power));
      chk("power_valid", 24'(pw[i] >= 8'h01 && pw[i] <= 8'hFA), 24'(o_desc.power_valid));
    end
    for (int a = 0; a < 16; a++) begin
      wr(`OTPCFG_OFS_ATTRIB, 8'(a));
      chk("attributes", 24'(8'h80 | ((a % 4 == 1 || a % 4 == 2) ? 8'h40 : 8'h00) |
          ((a / 4 == 3) ? 8'h20 : 8'h00)), 24'(o_desc.attributes));
      chk("power_mode", 24'((a % 4 == 0) ? otpcfg_pkg::OTPCFG_PWR_BUS : (a % 4 == 3) ?
          otpcfg_pkg::OTPCFG_PWR_INVALID : otpcfg_pkg::OTPCFG_PWR_SELF),
          24'(o_desc.power_mode));
    end
    // Careless writes to reserved bits and to an unmapped offset.
    foreach (pw[i]) begin
      wr((i == 4) ? 9'h001 : 9'h00A + 9'(i * 2 + (i == 3) * 7), 8'hFF, 1'b0);
      rd((i == 4) ? 9'h001 : 9'h00A + 9'(i * 2 + (i == 3) * 7),
         (i == 4) ? 8'h00 : (i == 3) ? 8'h0F : 8'h03);
    end
    // A second reset in mid-run clears the stored bytes again.
    @(negedge i_clk_sys);
    i_sys_rst = 1'b1;
    @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    @(negedge i_clk_sys);
    rd(`OTPCFG_OFS_DIR_LO, 8'h00);
    repeat (3) @(negedge i_clk_sys);
    chk("pin_dir", 24'(dflt_dir), 24'(o_chan.pin_dir));
    chk("tx_toggle", 24'h0, 24'(o_chan.tx_toggle_pin));
    chk("maker_id", 24'(dflt_maker), 24'(o_desc.maker_id));
    chk("queue empty", 24'h0, 24'(exp_q.size()));
    give_verdict();
  end
endmodule
